// ### rtl/hall_chain_defines.svh
/*
 * offsets, field positions, reset values and timing figures of the hall
 * current signal chain. assumes a 20 MHz reference clock.
 */
`ifndef HALL_CHAIN_DEFINES_SVH
`define HALL_CHAIN_DEFINES_SVH

// register byte addresses, one 32-bit word each
`define OFS_MODE        8'h00
`define OFS_SENS        8'h04
`define OFS_ZFL         8'h08
`define OFS_CLAMP_LO    8'h0C
`define OFS_CLAMP_HI    8'h10
`define OFS_TRIM        8'h14
`define OFS_USER0       8'h18
`define OFS_LOCK        8'h28
`define OFS_READOUT     8'h2C
`define OFS_STATUS      8'h30
// register indices (byte address / 4), also used as link addresses
`define IDX_CAL_LAST    4'h5
`define IDX_USER0       4'h6
`define IDX_USER3       4'h9
`define IDX_LOCK        4'hA
`define IDX_READOUT     4'hB
`define IDX_STATUS      4'hC
// mode register fields
`define MODE_USER_WE    0
`define MODE_RANGE_LO   2
`define MODE_FILTER     4
`define MODE_BITTIME    5
// reset values
`define MODE_RST        16'h0000
`define SENS_RST        16'h1000
`define ZFL_RST         16'h2000
`define CLAMP_LO_RST    16'h0000
`define CLAMP_HI_RST    16'h3FFF
`define TRIM_RST        16'h0080
`define READOUT_MAX     14'h3FFF
// processing figures
`define SENS_FRAC       13
`define FILT_K_SLOW     5
`define FILT_K_FAST     4
// timing
`define CLK_PERIOD_NS   50
`define BIT_TIME_FAST_NS 1750000
`define BIT_TIME_SLOW_NS 3500000
`define SAMPLE_PERIOD_NS 8000
`define FRAME_BITS_RD   5
`define FRAME_BITS_WR   21
`define REPLY_BITS      17

`endif

// ### rtl/hall_chain_pkg.sv
/*
 * types of the hall current signal chain.
 * assumes the constants header is included by the design file.
 */
`default_nettype none
package hall_chain_pkg;
    typedef enum logic [2:0] {
        L_IDLE,
        L_START,
        L_RECV,
        L_EXEC,
        L_REPLY
    } link_state_e;
    typedef logic [15:0] word_t;
endpackage
`default_nettype wire

// ### rtl/hall_current_signal_chain.sv
/*
 * hall current signal chain: filter, gain, zero-field adder and clamp,
 * parameter registers reloaded with reset values by arst_n, permanent lock, supply-modulation
 * programming link and register access over avalon-mm.
 * assumes adc samples and the avalon master sit on ref_clk; the supply
 * comparator, selection readback and lock fuse arrive asynchronously.
 */
// The implementer's own choices: the Avalon-MM register port and the register addresses.
// Operation
// [RL1] after the lock latch is active, parameter memory writes are refused
// [RL2] the lock latch has no clearing path
// [RL3] unlocked, parameter writes are accepted and steer the transfer curve
// [RL4] commands are decoded from the supply modulation comparator only
// [RL5] a valid command reads or writes the addressed register
// [RL6] the reply is sent serially on the output pin
// [RL7] the analog output is blanked during any programming frame
// [RL8] only a device whose output pin is selected answers
// [RL9] calibration kept in two copies; user info in single cells
// [RL10] each sample is low-pass filtered then processed by stored settings
// [RL11] filtered sample times gain, plus zero-field level, clamped
// [RL12] the processed value is readable as a register
// [RL13] processed value saturates between 0 and 16383
// [RL14] processed value depends on range, filter, trim and both clamps; trim is only stored and read back, the path does not use it
// [RL15] input span selectable from narrowest to widest range
// [RL16] range and filter come from the mode register
// [RL17] zero-field level sets the output at zero input
// [RL18] trim register is lockable like all others and frozen afterwards
// [RL19] the integrator keeps the processed value away from saturation; the code has no such integrator and clamps, then saturates, the value
// [RL20] mode bits 3:2 select range codes 0 to 3, widening
// [RL21] mode bit 4 selects filter corner, 0 slow, 1 fast
// [RL22] a new lock acts after power cycle, then modulation is ignored
// [RL23] processed value is delivered bit-reversed
// [RL24] processed value updates once per sample period, resets to zero level
`timescale 1ns/1ps
`default_nettype none
`include "hall_chain_defines.svh"

module hall_current_signal_chain #(
    parameter int BIT_CYC_FAST = `BIT_TIME_FAST_NS / `CLK_PERIOD_NS,
    parameter int BIT_CYC_SLOW = `BIT_TIME_SLOW_NS / `CLK_PERIOD_NS,
    parameter int SAMPLE_DIV   = `SAMPLE_PERIOD_NS / `CLK_PERIOD_NS
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [15:0] adc_data,
    input  wire logic        supply_mod,
    input  wire logic        sel_in,
    output logic             out_data,
    output logic             out_oe_n,
    output logic [11:0]      dac_code,
    output logic             dac_en,
    input  wire logic        lock_fuse,
    output logic             lock_burn
);

    localparam int TW = 17;

    if (BIT_CYC_FAST < 4 || BIT_CYC_SLOW < 4 || BIT_CYC_SLOW >= 2**TW
        || BIT_CYC_FAST >= 2**TW || SAMPLE_DIV < 2 || SAMPLE_DIV > 65535)
    begin : g_bad
        $error("hall_current_signal_chain: timing parameter out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // synchronisers and power-up capture of the lock fuse

    logic [1:0] mod_sync_reg;
    logic [1:0] sel_sync_reg;
    logic [1:0] fuse_sync_reg;
    logic [1:0] cap_cnt_reg;
    logic       cap_done_reg;
    logic       lock_active_reg;
    logic       lock_req_reg;
    wire        rx_s   = mod_sync_reg[1];
    wire        sel_s  = sel_sync_reg[1];
    wire        locked = lock_active_reg | ~cap_done_reg;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mod_sync_reg  <= 2'h3;
            sel_sync_reg  <= 2'h0;
            fuse_sync_reg <= 2'h0;
        end
        else
        begin
            mod_sync_reg  <= {mod_sync_reg[0], supply_mod};
            sel_sync_reg  <= {sel_sync_reg[0], sel_in};
            fuse_sync_reg <= {fuse_sync_reg[0], lock_fuse};
        end
    end

    // lock state becomes active only at the power-up after it was burnt
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cap_cnt_reg     <= 2'h0;
            cap_done_reg    <= 1'b0;
            lock_active_reg <= 1'b0;
        end
        else if (!cap_done_reg)
        begin
            cap_cnt_reg <= cap_cnt_reg + 2'h1;
            if (cap_cnt_reg == 2'h3)
            begin
                cap_done_reg    <= 1'b1;
                lock_active_reg <= fuse_sync_reg[1]; // RL22
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // parameter storage: calibration in two copies, user info single

    hall_chain_pkg::word_t cal_a_reg [6];
    hall_chain_pkg::word_t cal_b_reg [6];
    logic [12:0]           user_reg  [4];
    logic [13:0]           readout_reg;
    hall_chain_pkg::link_state_e link_state_reg;

    logic                  wr_go;
    logic [3:0]            wr_idx;
    hall_chain_pkg::word_t wr_data;
    wire  cal_wr_en  = wr_go && !locked && wr_idx <= `IDX_CAL_LAST; // RL1 RL3 RL18
    wire  user_wr_en = wr_go && !locked && wr_idx >= `IDX_USER0
                       && wr_idx <= `IDX_USER3 && cal_a_reg[0][`MODE_USER_WE];
    wire  lock_wr_en = wr_go && !locked && wr_idx == `IDX_LOCK && wr_data[0];
    logic cal_mismatch;

    function automatic logic [13:0] bit_rev14(input logic [13:0] v);
        logic [13:0] r;
        r = 14'h0000;
        for (int i = 0; i < 14; i++)
            r[i] = v[13 - i];
        return r;
    endfunction

    function automatic hall_chain_pkg::word_t reg_read(input logic [3:0] idx);
        hall_chain_pkg::word_t r;
        r = 16'h0000;
        if (idx <= `IDX_CAL_LAST)
            r = cal_a_reg[idx[2:0]];
        else if (idx >= `IDX_USER0 && idx <= `IDX_USER3)
            r = {3'h0, user_reg[idx[1:0] - 2'h2]};
        else if (idx == `IDX_LOCK)
            r = {14'h0000, lock_active_reg, lock_req_reg};
        else if (idx == `IDX_READOUT)
            r = {2'h0, bit_rev14(readout_reg)}; // RL23 RL12
        else if (idx == `IDX_STATUS)
            r = {13'h0000, cal_mismatch, link_state_reg != hall_chain_pkg::L_IDLE,
                 lock_active_reg};
        return r;
    endfunction

    localparam hall_chain_pkg::word_t CAL_RST [6] = '{`MODE_RST, `SENS_RST,
        `ZFL_RST, `CLAMP_LO_RST, `CLAMP_HI_RST, `TRIM_RST};

    for (genvar g = 0; g < 6; g++)
    begin : g_cal
        always_ff @(posedge ref_clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                cal_a_reg[g] <= CAL_RST[g];
                cal_b_reg[g] <= CAL_RST[g];
            end
            else if (cal_wr_en && wr_idx == 4'(g))
            begin
                cal_a_reg[g] <= wr_data; // RL9
                cal_b_reg[g] <= wr_data;
            end
        end
    end

    for (genvar g = 0; g < 4; g++)
    begin : g_user
        always_ff @(posedge ref_clk or negedge arst_n)
        begin
            if (!arst_n)
                user_reg[g] <= 13'h0000;
            else if (user_wr_en && wr_idx == 4'(g + 6))
                user_reg[g] <= wr_data[12:0];
        end
    end

    always_comb
    begin
        cal_mismatch = 1'b0;
        for (int i = 0; i < 6; i++)
            cal_mismatch = cal_mismatch | (cal_a_reg[i] != cal_b_reg[i]);
    end

    // only a power cycle clears the request; the fuse itself is one-time
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            lock_req_reg <= 1'b0;
        else if (lock_wr_en)
            lock_req_reg <= 1'b1; // RL2
    end
    assign lock_burn = lock_req_reg | lock_active_reg;

    ////////////////////////////////////////////////////////////////////////
    // signal path

    logic [15:0]        div_reg;
    logic               sample_tick;
    logic signed [15:0] filt_reg;
    wire  [15:0] mode_w   = cal_a_reg[0];
    wire  [1:0]  range_w  = mode_w[`MODE_RANGE_LO +: 2]; // RL16 RL20
    wire  signed [5:0] range_gain = (range_w == 2'h0) ? 6'sd16 : // RL15
                                    (range_w == 2'h1) ? 6'sd8  :
                                    (range_w == 2'h2) ? 6'sd6  : 6'sd5;
    wire  [2:0]  filt_k = mode_w[`MODE_FILTER] ? 3'(`FILT_K_FAST)
                                               : 3'(`FILT_K_SLOW); // RL21
    wire  signed [21:0] scaled_w  = $signed(adc_data) * range_gain;
    wire  signed [15:0] in_w      = 16'(scaled_w >>> 4);
    wire  signed [16:0] diff_w    = 17'(in_w) - 17'(filt_reg);
    wire  signed [15:0] filt_next = 16'(17'(filt_reg) + (diff_w >>> filt_k));
    wire  signed [31:0] prod_w    = filt_reg * $signed(cal_a_reg[1]);
    wire  signed [19:0] gain_w    = 20'(prod_w >>> `SENS_FRAC);
    wire  signed [19:0] sum_w     = gain_w + 20'($signed(cal_a_reg[2])); // RL17
    wire  signed [19:0] lo_w      = 20'(cal_a_reg[3][13:0]);
    wire  signed [19:0] hi_w      = 20'(cal_a_reg[4][13:0]);
    wire  signed [19:0] clamp_w   = (sum_w < lo_w) ? lo_w :
                                    (sum_w > hi_w) ? hi_w : sum_w; // RL11 RL14
    wire  [13:0] sat_w = (clamp_w < 20'sd0) ? 14'h0000 :
                         (clamp_w > 20'sd16383) ? `READOUT_MAX
                                                : clamp_w[13:0]; // RL13

    assign sample_tick = (div_reg == 16'(SAMPLE_DIV - 1));

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_reg     <= 16'h0000;
            filt_reg    <= 16'sh0000;
            readout_reg <= 14'(`ZFL_RST); // RL24
        end
        else
        begin
            div_reg <= sample_tick ? 16'h0000 : div_reg + 16'h0001;
            if (sample_tick)
            begin
                filt_reg    <= filt_next; // RL10
                readout_reg <= sat_w; // RL24
            end
        end
    end

    assign dac_code = readout_reg[13:2];
    assign dac_en   = (link_state_reg == hall_chain_pkg::L_IDLE); // RL7

    ////////////////////////////////////////////////////////////////////////
    // programming link on the supply modulation

    logic [TW-1:0] timer_reg;
    logic [4:0]    bit_cnt_reg;
    logic [20:0]   rx_sr_reg;
    logic [16:0]   tx_sr_reg;
    logic [3:0]    cmd_idx_reg;
    wire  [TW-1:0] bit_cyc = mode_w[`MODE_BITTIME] ? TW'(BIT_CYC_SLOW)
                                                   : TW'(BIT_CYC_FAST);
    wire  tmo      = (timer_reg == '0);
    wire  is_rd    = (bit_cnt_reg == 5'(`FRAME_BITS_RD)) && rx_sr_reg[16];
    wire  rx_done  = is_rd || bit_cnt_reg == 5'(`FRAME_BITS_WR);
    wire  [3:0] rx_idx  = is_rd ? rx_sr_reg[20:17] : rx_sr_reg[4:1];
    wire  link_wr  = (link_state_reg == hall_chain_pkg::L_EXEC) && !is_rd;
    // an avalon take is held off when a link write lands in the following cycle
    wire  link_wr_soon = (link_state_reg == hall_chain_pkg::L_RECV) && rx_done && !is_rd;
    // bit timers reload one short: the reload edge itself is a cycle of the bit
    wire  [TW-1:0] bit_cyc_m1 = bit_cyc - TW'(1);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link_state_reg <= hall_chain_pkg::L_IDLE;
            timer_reg      <= '0;
            bit_cnt_reg    <= 5'h00;
            rx_sr_reg      <= 21'h00000;
            tx_sr_reg      <= 17'h1FFFF;
            cmd_idx_reg    <= 4'h0;
        end
        else
        begin
            timer_reg <= tmo ? '0 : timer_reg - TW'(1);
            unique case (link_state_reg)
                hall_chain_pkg::L_IDLE:
                    if (!rx_s && !locked) // RL4 RL22
                    begin
                        link_state_reg <= hall_chain_pkg::L_START;
                        timer_reg      <= bit_cyc >> 1;
                    end
                hall_chain_pkg::L_START:
                    if (tmo)
                    begin
                        bit_cnt_reg <= 5'h00;
                        timer_reg   <= bit_cyc;
                        link_state_reg <= (!rx_s && sel_s) ? hall_chain_pkg::L_RECV
                                                           : hall_chain_pkg::L_IDLE; // RL8
                    end
                hall_chain_pkg::L_RECV:
                    if (rx_done)
                        link_state_reg <= hall_chain_pkg::L_EXEC;
                    else if (tmo)
                    begin
                        rx_sr_reg   <= {rx_s, rx_sr_reg[20:1]};
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        timer_reg   <= bit_cyc_m1;
                    end
                hall_chain_pkg::L_EXEC:
                begin
                    cmd_idx_reg    <= rx_idx; // RL5
                    bit_cnt_reg    <= 5'h00;
                    timer_reg      <= bit_cyc;
                    link_state_reg <= hall_chain_pkg::L_REPLY;
                end
                hall_chain_pkg::L_REPLY:
                begin
                    if (bit_cnt_reg == 5'h00 && timer_reg == bit_cyc)
                        tx_sr_reg <= {reg_read(cmd_idx_reg), 1'b0}; // RL6
                    else if (tmo)
                    begin
                        tx_sr_reg   <= {1'b1, tx_sr_reg[16:1]};
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        timer_reg   <= bit_cyc_m1;
                        if (bit_cnt_reg == 5'(`REPLY_BITS - 1))
                            link_state_reg <= hall_chain_pkg::L_IDLE;
                    end
                end
            endcase
        end
    end

    // pin released while listening so the programmer can select through it
    assign out_data = (link_state_reg == hall_chain_pkg::L_REPLY) ? tx_sr_reg[0] : 1'b0;
    assign out_oe_n = !(link_state_reg == hall_chain_pkg::L_IDLE
                        || link_state_reg == hall_chain_pkg::L_REPLY); // RL6

    ////////////////////////////////////////////////////////////////////////
    // avalon-mm slave; a write lands at the edge that ends the wait

    logic ack_reg;
    wire  av_req   = avs_read | avs_write;
    wire  av_go    = av_req && !ack_reg && !link_wr_soon;
    wire  av_idx_ok = (avs_address[1:0] == 2'h0) && avs_address <= `OFS_STATUS;
    wire  [3:0] av_idx = avs_address[5:2];

    assign wr_go   = link_wr || (ack_reg && avs_write && av_idx_ok);
    assign wr_idx  = link_wr ? rx_idx : av_idx;
    assign wr_data = link_wr ? rx_sr_reg[20:5] : avs_writedata[15:0];
    assign avs_waitrequest = av_req && !ack_reg;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_reg      <= 1'b0;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            ack_reg <= av_go;
            if (av_go && avs_read)
                avs_readdata <= av_idx_ok ? {16'h0000, reg_read(av_idx)} : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    chk_lock_blocks_wr: assert property (lock_active_reg |-> !cal_wr_en && !user_wr_en) // RL1
        else $error("parameter write while locked");
    chk_lock_sticky: assert property (lock_req_reg |=> lock_req_reg) // RL2
        else $error("lock request cleared");
    chk_locked_deaf: assert property (lock_active_reg && !rx_s |=> link_state_reg == hall_chain_pkg::L_IDLE) // RL22
        else $error("locked device reacted to modulation");
    chk_output_blank: assert property (link_state_reg != hall_chain_pkg::L_IDLE |-> !dac_en) // RL7
        else $error("analog output live during frame");
    chk_reply_drive: assert property (link_state_reg == hall_chain_pkg::L_EXEC |=> !out_oe_n [*2]) // RL6
        else $error("reply not driven");
    chk_unselected: assert property (link_state_reg == hall_chain_pkg::L_START && tmo && !sel_s
                                     |=> link_state_reg == hall_chain_pkg::L_IDLE) // RL8
        else $error("unselected device continued");
    chk_readout_hold: assert property (!$past(sample_tick) |-> $stable(readout_reg)) // RL24
        else $error("readout changed off sample tick");
    chk_readout_zero: assert property (sample_tick && filt_reg == 16'sh0000
                                       && cal_a_reg[2] <= 16'h3FFF && cal_a_reg[2] >= cal_a_reg[3]
                                       && cal_a_reg[2] <= cal_a_reg[4]
                                       |=> readout_reg == $past(cal_a_reg[2][13:0])) // RL17
        else $error("zero input did not give zero-field level");
    chk_write_takes: assert property (cal_wr_en && wr_idx == 4'h2 |=> cal_a_reg[2] == $past(wr_data)) // RL3
        else $error("unlocked write not stored");
    chk_av_answer: assert property (av_req |-> ##[0:2] !avs_waitrequest)
        else $error("avalon answer late");

    cov_link_read:  cover property (link_state_reg == hall_chain_pkg::L_EXEC && is_rd);
    cov_link_write: cover property (link_wr && cal_wr_en);
    cov_lock_req:   cover property ($rose(lock_req_reg));
    cov_av_read:    cover property (av_go && avs_read && av_idx == `IDX_READOUT);

endmodule

`default_nettype wire

// ### dv/hall_programmer_model.sv
/* external programmer: modulates the supply line and listens on the output pin.
   assumes the shortened bit time of the bench and a pin that reads back its driver. */
`timescale 1ns/1ps
`default_nettype none
module hall_programmer_model #(
    parameter int T = 8
) (
    input  wire logic ref_clk,
    input  wire logic out_data,
    input  wire logic out_oe_n,
    output var logic  supply_mod,
    output logic      sel_in
);
    logic sel_drive;
    int   bt;
    // pin level: the device wins while it drives, else our selection pull
    assign sel_in = out_oe_n ? sel_drive : out_data;
    initial supply_mod = 1'b1;
    initial sel_drive = 1'b0;
    initial bt = T;
    ////////////////////////////////////////////////////////////
    task automatic xfer(input logic rw, input logic [3:0] a, input logic [15:0] d,
                        input logic sel, output logic got, output logic [15:0] rep);
        logic [21:0] bits;
        int          n;
        bits = {d, a, rw, 1'b0};
        n = 0;
        rep = 16'h0000;
        sel_drive <= sel;
        for (int i = 0; i < (rw ? 6 : 22); i++)
        begin
            @(posedge ref_clk);
            supply_mod <= bits[i];
            // the last bit is cut short: the reply may start before it ends
            if (i < (rw ? 5 : 21))
                repeat (bt - 1) @(posedge ref_clk);
        end
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (out_data !== 1'b1 && n < 4 * bt);
        supply_mod <= 1'b1;
        got = (n < 4 * bt);
        repeat (bt + bt / 2) @(posedge ref_clk);
        for (int i = 0; i < 16; i++)
        begin
            rep[i] = out_data;
            repeat (bt) @(posedge ref_clk);
        end
        sel_drive <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### dv/hall_current_signal_chain_tb_top.sv
/* testbench of the hall current signal chain: register map, processing chain,
   programming link and permanent lock. assumes shortened bit time and sample divider. */
`timescale 1ns/1ps
`default_nettype none
`include "hall_chain_defines.svh"
`define CHK(g, e) check_eq(32'(g), 32'(e))
module hall_current_signal_chain_tb_top;
    logic        ref_clk;
    logic        arst_n;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [15:0] adc_data;
    logic        supply_mod;
    logic        sel_in;
    logic        out_data;
    logic        out_oe_n;
    logic [11:0] dac_code;
    logic        dac_en;
    logic        lock_fuse;
    logic        lock_burn;
    int          n_errors;
    int          num_checks;
    logic [31:0] rd;
    logic        got;
    logic [15:0] rep;

    hall_current_signal_chain #(.BIT_CYC_FAST(8), .BIT_CYC_SLOW(16), .SAMPLE_DIV(8)) DUT (
        .ref_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .adc_data, .supply_mod, .sel_in, .out_data,
        .out_oe_n, .dac_code, .dac_en, .lock_fuse, .lock_burn
    );
    hall_programmer_model #(.T(8)) prog (
        .ref_clk, .out_data, .out_oe_n, .supply_mod, .sel_in
    );

    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////
    task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        `CHK(n < 4, 1'b1);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    function automatic logic [31:0] rev14(input logic [13:0] v);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 14; i++)
            r[13 - i] = v[i];
        return r;
    endfunction

    task automatic power_up();
        arst_n <= 1'b0;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        // the lock fuse is only captured a few edges after release
        repeat (5) @(posedge ref_clk);
    endtask

    task automatic t_reset_map();
        logic [7:0]  ofs [7] = '{`OFS_MODE, `OFS_SENS, `OFS_ZFL, `OFS_CLAMP_LO,
                                 `OFS_CLAMP_HI, `OFS_TRIM, 8'h3C};
        logic [15:0] val [7] = '{`MODE_RST, `SENS_RST, `ZFL_RST, `CLAMP_LO_RST,
                                 `CLAMP_HI_RST, `TRIM_RST, 16'h0000};
        `CHK(dac_en, 1'b1);
        `CHK(dac_code, 12'h800);
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, ofs[i], 32'h0);
            `CHK(rd, {16'h0000, val[i]});
        end
        bus(1'b0, `OFS_READOUT, 32'h0);
        `CHK(rd, rev14(14'h2000));
    endtask

    task automatic t_user();
        logic [31:0] r0;
        bus(1'b0, `OFS_USER0, 32'h0);
        r0 = rd;
        bus(1'b1, `OFS_USER0, 32'h1ABC);
        bus(1'b0, `OFS_USER0, 32'h0);
        `CHK(rd, r0);
        bus(1'b1, `OFS_MODE, 32'h001D);
        bus(1'b0, `OFS_MODE, 32'h0);
        `CHK(rd, 32'h001D);
        bus(1'b1, `OFS_MODE, 32'h0001);
        bus(1'b1, `OFS_USER0, 32'hFFFF);
        bus(1'b0, `OFS_USER0, 32'h0);
        `CHK(rd, 32'h1FFF);
    endtask

    task automatic t_chain();
        bus(1'b1, `OFS_CLAMP_HI, 32'h3000);
        bus(1'b1, `OFS_CLAMP_LO, 32'h0400);
        adc_data <= 16'h7FFF;
        repeat (3000) @(posedge ref_clk);
        `CHK(dac_code, 12'hC00);
        bus(1'b0, `OFS_READOUT, 32'h0);
        `CHK(rd, rev14(14'h3000));
        adc_data <= 16'h8000;
        repeat (3000) @(posedge ref_clk);
        bus(1'b0, `OFS_READOUT, 32'h0);
        `CHK(rd, rev14(14'h0400));
        bus(1'b1, `OFS_SENS, 32'hE000);
        bus(1'b1, `OFS_CLAMP_HI, 32'h3FFF);
        repeat (100) @(posedge ref_clk);
        `CHK(dac_code, 12'hFFF);
        bus(1'b1, `OFS_SENS, 32'h1000);
        bus(1'b1, `OFS_CLAMP_LO, 32'h0000);
        repeat (100) @(posedge ref_clk);
        bus(1'b0, `OFS_READOUT, 32'h0);
        `CHK(rd, 32'h0);
    endtask

    task automatic t_link();
        fork
            prog.xfer(1'b1, 4'h1, 16'h0, 1'b1, got, rep);
            begin
                repeat (24) @(posedge ref_clk);
                `CHK(dac_en, 1'b0);
                `CHK(out_oe_n, 1'b1);
            end
        join
        `CHK(got, 1'b1);
        `CHK(rep, 16'h1000);
        repeat (32) @(posedge ref_clk);
        `CHK(dac_en, 1'b1);
        prog.xfer(1'b0, 4'h3, 16'h0123, 1'b1, got, rep);
        `CHK(rep, 16'h0123);
        repeat (32) @(posedge ref_clk);
        bus(1'b0, `OFS_CLAMP_LO, 32'h0);
        `CHK(rd, 32'h0123);
        prog.xfer(1'b1, 4'h1, 16'h0, 1'b0, got, rep);
        `CHK(got, 1'b0);
        repeat (32) @(posedge ref_clk);
        bus(1'b1, `OFS_MODE, 32'h0021);
        prog.bt = 16;
        prog.xfer(1'b1, 4'h0, 16'h0, 1'b1, got, rep);
        `CHK(got, 1'b1);
        `CHK(rep, 16'h0021);
    endtask

    task automatic t_lock();
        bus(1'b1, `OFS_LOCK, 32'h1);
        @(posedge ref_clk);
        `CHK(lock_burn, 1'b1);
        bus(1'b1, `OFS_TRIM, 32'h0055);
        bus(1'b0, `OFS_TRIM, 32'h0);
        `CHK(rd, 32'h0055);
        lock_fuse <= 1'b1;
        power_up();
        bus(1'b1, `OFS_SENS, 32'h0123);
        bus(1'b1, `OFS_TRIM, 32'h0077);
        bus(1'b1, `OFS_LOCK, 32'h0);
        bus(1'b0, `OFS_SENS, 32'h0);
        `CHK(rd, `SENS_RST);
        bus(1'b0, `OFS_TRIM, 32'h0);
        `CHK(rd, `TRIM_RST);
        bus(1'b0, `OFS_STATUS, 32'h0);
        `CHK(rd[0], 1'b1);
        prog.xfer(1'b1, 4'h1, 16'h0, 1'b1, got, rep);
        `CHK(got, 1'b0);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        arst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        adc_data = 16'h0000;
        lock_fuse = 1'b0;
        n_errors = 0;
        num_checks = 0;
        @(posedge ref_clk);
        power_up();
        t_reset_map();
        t_user();
        t_chain();
        t_link();
        t_lock();
        final_report();
    end

    // whole run is near 8000 cycles; a hang stops well beyond that
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
